// ==== rtl/cas_pkg.sv ====
// constants and types shared by the architectural state sequencer
package cas_pkg;
  // ---------------------------------------------------------------
  // widths and increments
  // ---------------------------------------------------------------
  localparam int          PC_WIDTH        = 32;
  localparam int          DATA_WIDTH      = 32;
  localparam int          REG_IDX_WIDTH   = 5;
  localparam int          NUM_SETS        = 4;
  localparam int          PHYS_ADDR_WIDTH = 32;
  localparam logic [31:0] PC_STEP_SHORT   = 32'h0000_0002;
  localparam logic [31:0] PC_STEP_WORD    = 32'h0000_0004;
  localparam logic [31:0] PC_RESET_VALUE  = 32'hBFC0_0000;
  localparam logic [4:0]  ZERO_REG_IDX    = 5'h00;
  localparam logic [4:0]  LINK_REG_IDX    = 5'h1F;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic ORDER_LITTLE    = 1'h0;
  localparam logic ORDER_BIG       = 1'h1;
  localparam logic ISA_STANDARD    = 1'h0;
  localparam logic ISA_COMPRESSED  = 1'h1;
  localparam logic FPR_NARROW      = 1'h0;
  localparam logic FPR_WIDE        = 1'h1;

  // ---------------------------------------------------------------
  // execution privilege and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CAS_MODE_KERNEL     = 2'h0,
    CAS_MODE_SUPERVISOR = 2'h1,
    CAS_MODE_USER       = 2'h2
  } cas_mode_t;

  typedef enum logic [2:0] {
    CAS_ST_SEQ    = 3'b001,
    CAS_ST_SLOT   = 3'b010,
    CAS_ST_FAULT  = 3'b100
  } cas_state_t;

  // ---------------------------------------------------------------
  // logical shift helpers, vacated bits filled with zero
  // ---------------------------------------------------------------
  function automatic logic [31:0] cas_shl(input logic [31:0] v, input logic [4:0] n);
    cas_shl = v << n;
  endfunction

  function automatic logic [31:0] cas_shr(input logic [31:0] v, input logic [4:0] n);
    cas_shr = v >> n;
  endfunction
endpackage

// ==== rtl/cas_regfile.sv ====
// shadowed general register sets with hard zero register
`timescale 1ns/1ns
module cas_regfile #(
  parameter int SETS = cas_pkg::NUM_SETS,
  parameter int SW   = (SETS > 1) ? $clog2(SETS) : 1
) (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic [SW-1:0]             set_sel,
  input  wire logic [4:0]                rd_idx,
  output logic      [31:0]               rd_data,
  input  wire logic                      wr_en,
  input  wire logic [4:0]                wr_idx,
  input  wire logic [31:0]               wr_data
);
  logic [31:0] mem_reg [SETS*32];
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic        wr_ok;

  always_comb begin
    // register zero never stored and always reads zero
    wr_ok = wr_en && (wr_idx != cas_pkg::ZERO_REG_IDX);
    if (rd_idx == cas_pkg::ZERO_REG_IDX) begin
      rd_data_next = 32'h0000_0000;
    end else begin
      rd_data_next = mem_reg[{set_sel, rd_idx}];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_ok) begin
      mem_reg[{set_sel, wr_idx}] <= wr_data;
    end
    if (reset) begin
      rd_data_reg <= 32'h0000_0000;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
endmodule

// ==== rtl/cas_endian.sv ====
// byte order resolution for loads and stores
`timescale 1ns/1ns
module cas_endian (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              strap_byte_order,
  input  wire logic              user_endian_swap_bit,
  input  wire cas_pkg::cas_mode_t mode,
  output logic                   memory_byte_order,
  output logic                   swap_byte_order_active,
  output logic                   access_byte_order
);
  logic memory_byte_order_reg;
  logic memory_byte_order_next;
  logic swap_reg;
  logic swap_next;
  logic access_reg;
  logic access_next;

  always_comb begin
    // strap is caught by the clock while reset is held
    memory_byte_order_next = reset ? strap_byte_order : memory_byte_order_reg;
    swap_next   = user_endian_swap_bit && (mode == cas_pkg::CAS_MODE_USER);
    access_next = memory_byte_order_reg ^ swap_next;
  end

  always_ff @(posedge clk_sys) begin
    memory_byte_order_reg <= memory_byte_order_next;
    if (reset) begin
      swap_reg   <= 1'h0;
      access_reg <= 1'h0;
    end else begin
      swap_reg   <= swap_next;
      access_reg <= access_next;
    end
  end

  assign memory_byte_order      = memory_byte_order_reg;
  assign swap_byte_order_active = swap_reg;
  assign access_byte_order      = access_reg;
endmodule

// ==== rtl/cas_core_state.sv ====
// architectural state sequencing: pc, delay slot, instruction_set_select, link flag
`timescale 1ns/1ns
// What this block does
// - register zero reads zero, writes ignored
// - register references use current shadow set
// - byte order latched at reset for kernel
// - access order is memory order xor swap
// - swap active only in user mode with bit
// - linked load sets flag, conditional store tests
// - flag cleared on conflicting store, exception return
// - pc advances 2 or 4 when unassigned
// - branch target loaded during delay slot instruction
// - link address to register, exception address saved
// - pc kept as full 32-bit address
// - one-bit instruction set mode, 0 standard
// - saved address combines pc and mode bit
// - physical address width configurable, 2^width bytes
// - fpr width bit selects 32 or 64-bit
// - delay slot flag only for executed slots
// - faulting instruction performs no later steps
// - results may appear after following instruction
// - logical shifts fill vacated bits with zero
module cas_core_state #(
  parameter int SETS       = cas_pkg::NUM_SETS,
  parameter int PA_WIDTH   = cas_pkg::PHYS_ADDR_WIDTH,
  parameter int SW         = (SETS > 1) ? $clog2(SETS) : 1
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 strap_byte_order,
  input  wire logic                 user_endian_swap_bit,
  input  wire cas_pkg::cas_mode_t   mode,
  input  wire logic [SW-1:0]        current_shadow_set,
  input  wire logic                 fpr_width_select,
  input  wire logic                 instr_valid,
  input  wire logic                 instr_short,
  input  wire logic                 branch_taken,
  input  wire logic [31:0]          branch_target,
  input  wire logic                 target_isa,
  input  wire logic                 link_write,
  input  wire logic [4:0]           link_idx,
  input  wire logic                 jump_assign,
  input  wire logic [31:0]          jump_target,
  input  wire logic                 fault_req,
  input  wire logic [4:0]           fault_type,
  input  wire logic [31:0]          fault_arg,
  input  wire logic [31:0]          fault_vector,
  input  wire logic                 load_linked,
  input  wire logic                 store_cond,
  input  wire logic                 store_conflict,
  input  wire logic                 exc_return,
  input  wire logic [31:0]          exc_return_pc,
  input  wire logic                 gr_wr_en,
  input  wire logic [4:0]           gr_wr_idx,
  input  wire logic [31:0]          gr_wr_data,
  input  wire logic [4:0]           gr_rd_idx,
  input  wire logic [31:0]          shift_value,
  input  wire logic [4:0]           shift_amount,
  input  wire logic                 shift_right,
  input  wire logic [31:0]          data_addr,
  output logic [31:0]               gr_rd_data,
  output logic [31:0]               pc,
  output logic                      instruction_set_select,
  output logic                      in_delay_slot_flag,
  output logic                      link_reservation_flag,
  output logic                      store_cond_success,
  output logic                      raise_fault,
  output logic [4:0]                fault_type_out,
  output logic [31:0]               fault_arg_out,
  output logic [31:0]               restart_addr,
  output logic                      restart_valid,
  output logic [31:0]               shift_result,
  output logic [PA_WIDTH-1:0]       phys_addr,
  output logic                      narrow_fpr_mode,
  output logic                      memory_byte_order,
  output logic                      swap_byte_order_active,
  output logic                      access_byte_order
);
  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  cas_pkg::cas_state_t state_reg;
  cas_pkg::cas_state_t state_next;
  logic [31:0] pc_reg;
  logic [31:0] pc_next;
  logic        isa_reg;
  logic        isa_next;
  logic [31:0] pending_target_reg;
  logic [31:0] pending_target_next;
  logic        pending_isa_reg;
  logic        pending_isa_next;
  logic        slot_flag_reg;
  logic        slot_flag_next;
  logic        llflag_reg;
  logic        llflag_next;
  logic        sc_ok_reg;
  logic        sc_ok_next;
  logic        fault_reg;
  logic        fault_next;
  logic [4:0]  ftype_reg;
  logic [4:0]  ftype_next;
  logic [31:0] farg_reg;
  logic [31:0] farg_next;
  logic [31:0] restart_reg;
  logic [31:0] restart_next;
  logic        restart_v_reg;
  logic        restart_v_next;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [PA_WIDTH-1:0] pa_reg;
  logic [PA_WIDTH-1:0] pa_next;
  logic        fpr_reg;
  logic        fpr_next;
  logic        rf_wr_en;
  logic [4:0]  rf_wr_idx;
  logic [31:0] rf_wr_data;
  logic [31:0] seq_pc;

  // combines pc upper bits with mode bit as one saved value
  function automatic logic [31:0] cas_restart(input logic [31:0] p, input logic m);
    cas_restart = {p[31:1], m};
  endfunction

  // ---------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------
  cas_regfile #(
    .SETS (SETS),
    .SW   (SW)
  ) u_regfile (
    .clk_sys (clk_sys),
    .reset   (reset),
    .set_sel (current_shadow_set),
    .rd_idx  (gr_rd_idx),
    .rd_data (gr_rd_data),
    .wr_en   (rf_wr_en),
    .wr_idx  (rf_wr_idx),
    .wr_data (rf_wr_data)
  );

  cas_endian u_endian (
    .clk_sys                (clk_sys),
    .reset                  (reset),
    .strap_byte_order       (strap_byte_order),
    .user_endian_swap_bit   (user_endian_swap_bit),
    .mode                   (mode),
    .memory_byte_order      (memory_byte_order),
    .swap_byte_order_active (swap_byte_order_active),
    .access_byte_order      (access_byte_order)
  );

  // ---------------------------------------------------------------
  // register file write steering
  // ---------------------------------------------------------------
  always_comb begin
    // link address write takes precedence over data writes; a faulting instruction writes nothing
    seq_pc     = pc_reg + (instr_short ? cas_pkg::PC_STEP_SHORT : cas_pkg::PC_STEP_WORD);
    rf_wr_en   = 1'h0;
    rf_wr_idx  = gr_wr_idx;
    rf_wr_data = gr_wr_data;
    if (instr_valid && !fault_req) begin
      if (link_write) begin
        rf_wr_en   = 1'h1;
        rf_wr_idx  = link_idx;
        rf_wr_data = cas_restart(pc_reg + 32'h0000_0008, isa_reg);
      end else begin
        rf_wr_en   = gr_wr_en;
      end
    end
  end

  // ---------------------------------------------------------------
  // program counter and delay slot sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_next          = state_reg;
    pc_next             = pc_reg;
    isa_next            = isa_reg;
    pending_target_next = pending_target_reg;
    pending_isa_next    = pending_isa_reg;
    slot_flag_next      = slot_flag_reg;
    fault_next          = 1'h0;
    ftype_next          = ftype_reg;
    farg_next           = farg_reg;
    restart_next        = restart_reg;
    restart_v_next      = 1'h0;
    if (instr_valid) begin
      if (fault_req) begin
        // fault stops the instruction at once, no later steps
        fault_next     = 1'h1;
        ftype_next     = fault_type;
        farg_next      = fault_arg;
        restart_next   = cas_restart(pc_reg, isa_reg);
        restart_v_next = 1'h1;
        pc_next        = fault_vector;
        slot_flag_next = 1'h0;
        state_next     = cas_pkg::CAS_ST_FAULT;
      end else if (exc_return) begin
        pc_next        = exc_return_pc;
        slot_flag_next = 1'h0;
        state_next     = cas_pkg::CAS_ST_SEQ;
      end else begin
        unique case (state_reg)
          cas_pkg::CAS_ST_SEQ, cas_pkg::CAS_ST_FAULT: begin
            slot_flag_next = 1'h0;
            state_next     = cas_pkg::CAS_ST_SEQ;
            if (branch_taken) begin
              // target held until the delay slot instruction executes
              pending_target_next = branch_target;
              pending_isa_next    = target_isa;
              slot_flag_next      = 1'h1;
              pc_next             = seq_pc;
              state_next          = cas_pkg::CAS_ST_SLOT;
            end else if (jump_assign) begin
              pc_next = jump_target;
            end else begin
              pc_next = seq_pc;
            end
          end
          cas_pkg::CAS_ST_SLOT: begin
            pc_next        = pending_target_reg;
            isa_next       = pending_isa_reg;
            slot_flag_next = 1'h0;
            state_next     = cas_pkg::CAS_ST_SEQ;
          end
          default: begin
            state_next = cas_pkg::CAS_ST_SEQ;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // link reservation and conditional store
  // ---------------------------------------------------------------
  always_comb begin
    llflag_next = llflag_reg;
    sc_ok_next  = 1'h0;
    if (instr_valid && !fault_req) begin
      if (store_cond) begin
        sc_ok_next  = llflag_reg;
        llflag_next = 1'h0;
      end
      if (store_conflict || exc_return) begin
        llflag_next = 1'h0;
      end
      // a new linked load wins over a clear in the same cycle
      if (load_linked) begin
        llflag_next = 1'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // shifter, physical address, fpr width
  // ---------------------------------------------------------------
  always_comb begin
    shift_next = shift_right ? cas_pkg::cas_shr(shift_value, shift_amount)
                             : cas_pkg::cas_shl(shift_value, shift_amount);
    pa_next    = data_addr[PA_WIDTH-1:0];
    fpr_next   = (fpr_width_select == cas_pkg::FPR_NARROW);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg          <= cas_pkg::CAS_ST_SEQ;
      pc_reg             <= cas_pkg::PC_RESET_VALUE;
      isa_reg            <= cas_pkg::ISA_STANDARD;
      pending_target_reg <= 32'h0000_0000;
      pending_isa_reg    <= cas_pkg::ISA_STANDARD;
      slot_flag_reg      <= 1'h0;
      llflag_reg         <= 1'h0;
      sc_ok_reg          <= 1'h0;
      fault_reg          <= 1'h0;
      ftype_reg          <= 5'h00;
      farg_reg           <= 32'h0000_0000;
      restart_reg        <= 32'h0000_0000;
      restart_v_reg      <= 1'h0;
      shift_reg          <= 32'h0000_0000;
      pa_reg             <= '0;
      fpr_reg            <= 1'h1;
    end else begin
      state_reg          <= state_next;
      pc_reg             <= pc_next;
      isa_reg            <= isa_next;
      pending_target_reg <= pending_target_next;
      pending_isa_reg    <= pending_isa_next;
      slot_flag_reg      <= slot_flag_next;
      llflag_reg         <= llflag_next;
      sc_ok_reg          <= sc_ok_next;
      fault_reg          <= fault_next;
      ftype_reg          <= ftype_next;
      farg_reg           <= farg_next;
      restart_reg        <= restart_next;
      restart_v_reg      <= restart_v_next;
      shift_reg          <= shift_next;
      pa_reg             <= pa_next;
      fpr_reg            <= fpr_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pc                     = pc_reg;
  assign instruction_set_select = isa_reg;
  assign in_delay_slot_flag     = slot_flag_reg;
  assign link_reservation_flag  = llflag_reg;
  assign store_cond_success     = sc_ok_reg;
  assign raise_fault            = fault_reg;
  assign fault_type_out         = ftype_reg;
  assign fault_arg_out          = farg_reg;
  assign restart_addr           = restart_reg;
  assign restart_valid          = restart_v_reg;
  assign shift_result           = shift_reg;
  assign phys_addr              = pa_reg;
  assign narrow_fpr_mode        = fpr_reg;
endmodule

// ==== verification/cas_core_state_asserts.sv ====
// concurrent checks on the architectural state sequencer ports
`timescale 1ns/1ns
module cas_core_state_asserts (
  input wire logic               clk_sys,
  input wire logic               reset,
  input wire logic               user_endian_swap_bit,
  input wire cas_pkg::cas_mode_t mode,
  input wire logic               fpr_width_select,
  input wire logic               instr_valid,
  input wire logic               instr_short,
  input wire logic               branch_taken,
  input wire logic               jump_assign,
  input wire logic               fault_req,
  input wire logic [31:0]        fault_vector,
  input wire logic               load_linked,
  input wire logic               exc_return,
  input wire logic [4:0]         gr_rd_idx,
  input wire logic [31:0]        shift_value,
  input wire logic [4:0]         shift_amount,
  input wire logic               shift_right,
  input wire logic [31:0]        gr_rd_data,
  input wire logic [31:0]        pc,
  input wire logic               instruction_set_select,
  input wire logic               in_delay_slot_flag,
  input wire logic               link_reservation_flag,
  input wire logic               raise_fault,
  input wire logic [31:0]        restart_addr,
  input wire logic [31:0]        shift_result,
  input wire logic               narrow_fpr_mode,
  input wire logic               memory_byte_order,
  input wire logic               swap_byte_order_active,
  input wire logic               access_byte_order
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  zero_reg_read_a: assert property (
    !$past(reset) && $past(gr_rd_idx) == 5'h00 |-> gr_rd_data == 32'h0) else $error("r0 not zero");
  swap_user_a: assert property (
    !$past(reset) |-> swap_byte_order_active ==
    ($past(user_endian_swap_bit) && $past(mode) == cas_pkg::CAS_MODE_USER)) else $error("swap");
  access_xor_a: assert property (
    !$past(reset) && $stable(swap_byte_order_active) |->
    access_byte_order == (memory_byte_order ^ swap_byte_order_active)) else $error("access order");
  fpr_mode_a: assert property (
    !$past(reset) |-> narrow_fpr_mode == !$past(fpr_width_select)) else $error("fpr mode");
  shift_fill_a: assert property (
    !$past(reset) |-> shift_result == ($past(shift_right) ? $past(shift_value) >> $past(shift_amount)
    : $past(shift_value) << $past(shift_amount))) else $error("shift");
  pc_advance_a: assert property (
    instr_valid && !in_delay_slot_flag && !branch_taken && !jump_assign && !fault_req && !exc_return
    |=> pc == $past(pc) + ($past(instr_short) ? 32'h2 : 32'h4)) else $error("pc step");
  slot_end_a: assert property (
    instr_valid && in_delay_slot_flag && !fault_req |=> !in_delay_slot_flag) else $error("slot");
  link_set_a: assert property (
    instr_valid && load_linked && !fault_req |=> link_reservation_flag) else $error("link flag");
  fault_entry_a: assert property (
    instr_valid && fault_req && !in_delay_slot_flag |=> raise_fault && pc == $past(fault_vector)
    && restart_addr == {$past(pc[31:1]), $past(instruction_set_select)}) else $error("fault");
endmodule

// ==== verification/cas_mem_model.sv ====
// data memory model answering byte reads in the selected byte order
`timescale 1ns/1ns
module cas_mem_model (
  input  wire logic [31:0] phys_addr,
  input  wire logic        access_byte_order,
  output logic      [7:0]  mem_byte
);
  logic [31:0] word;
  logic [1:0]  lane;
  always_comb begin
    word = {phys_addr[31:2], 2'h0} ^ 32'hA5C3_0F96;
    lane = access_byte_order ? 2'h3 - phys_addr[1:0] : phys_addr[1:0];
    mem_byte = 8'(word >> {lane, 3'h0});
  end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the architectural state sequencer
`timescale 1ns/1ns
module testbench;
  logic clk_sys = '0, reset = 1'h1, strap_byte_order = 1'h1, user_endian_swap_bit = '0;
  logic fpr_width_select = '0, instr_valid = '0, instr_short = '0, branch_taken = '0;
  logic target_isa = '0, link_write = '0, jump_assign = '0, fault_req = '0, load_linked = '0;
  logic store_cond = '0, store_conflict = '0, exc_return = '0, gr_wr_en = '0, shift_right = '0;
  cas_pkg::cas_mode_t mode = cas_pkg::CAS_MODE_KERNEL;
  logic [1:0]  current_shadow_set = '0, s;
  logic [4:0]  link_idx = '0, fault_type = '0, gr_wr_idx = '0, gr_rd_idx = '0, shift_amount = '0;
  logic [31:0] branch_target = '0, jump_target = '0, fault_arg = '0, fault_vector = '0;
  logic [31:0] exc_return_pc = '0, gr_wr_data = '0, shift_value = '0, data_addr = '0;
  logic [31:0] gr_rd_data, pc, fault_arg_out, restart_addr, shift_result, phys_addr;
  logic [4:0]  fault_type_out, ix;
  logic [7:0]  mem_byte;
  logic instruction_set_select, in_delay_slot_flag, link_reservation_flag, store_cond_success;
  logic raise_fault, restart_valid, narrow_fpr_mode, memory_byte_order;
  logic swap_byte_order_active, access_byte_order, sw_m, ord_m;
  int   miscompares = 0, tests_run = 0;
  logic [31:0] seed = 32'h79D9, pc_m, x, t, w;
  logic [31:0] regs_m [4][32];
  bit          wr_m [4][32];
  always #4 clk_sys = ~clk_sys;
  cas_core_state uut (.*);
  cas_mem_model partner (.phys_addr, .access_byte_order, .mem_byte);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // let the taking edge pass, drop the instruction, advance the pc model
  task fin(input logic [31:0] step);
    @(posedge clk_sys);
    {instr_valid, instr_short, branch_taken, target_isa, link_write, jump_assign, fault_req,
     load_linked, store_cond, store_conflict, exc_return, gr_wr_en} <= '0;
    #1;
    pc_m = pc_m + step;
  endtask
  task go(input logic [3:0] f);
    @(posedge clk_sys);
    instr_valid <= 1'h1;
    {load_linked, store_cond, store_conflict, exc_return} <= f;
    fin(32'h4);
  endtask
  task rd(input logic [1:0] st, input logic [4:0] id);
    @(posedge clk_sys);
    current_shadow_set <= st;
    gr_rd_idx <= id;
    @(posedge clk_sys);
    #1;
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    stop_test();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'h0;
    // strap moves after release; the latched order must not follow it
    strap_byte_order <= 1'h0;
    @(posedge clk_sys);
    #1;
    pc_m = cas_pkg::PC_RESET_VALUE;
    chk("pc_rst", pc, pc_m);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      mode <= cas_pkg::cas_mode_t'(2'(i % 3));
      user_endian_swap_bit <= 1'((i / 3) % 2);
      fpr_width_select <= 1'(i / 6);
      repeat (2) @(posedge clk_sys);
      #1;
      sw_m = ((i / 3) % 2 == 1) && (i % 3 == 2);
      ord_m = 1'h1 ^ sw_m;
      chk("mem_order", memory_byte_order, 32'h1);
      chk("swap", swap_byte_order_active, sw_m);
      chk("access", access_byte_order, ord_m);
      chk("narrow", narrow_fpr_mode, i < 6);
    end
    for (int i = 0; i < 16; i++) begin
      x = xs();
      t = xs();
      ix = (i < 2) ? 5'h00 : x[6:2];
      @(posedge clk_sys);
      {instr_valid, gr_wr_en} <= 2'h3;
      instr_short <= x[8];
      current_shadow_set <= x[1:0];
      gr_wr_idx <= ix;
      gr_wr_data <= t;
      shift_value <= t;
      shift_amount <= x[13:9];
      shift_right <= x[14];
      data_addr <= x;
      fin(x[8] ? 32'h2 : 32'h4);
      if (ix != 5'h00) begin
        regs_m[x[1:0]][ix] = t;
        wr_m[x[1:0]][ix] = 1'b1;
      end
      w = ({x[31:2], 2'h0} ^ 32'hA5C3_0F96) >> {(ord_m ? 2'h3 - x[1:0] : x[1:0]), 3'h0};
      chk("pc", pc, pc_m);
      chk("shift", shift_result, x[14] ? t >> x[13:9] : t << x[13:9]);
      chk("phys", phys_addr, x);
      chk("byte", mem_byte, w[7:0]);
      s = i[0] ? x[1:0] : t[1:0];
      ix = i[0] ? ix : t[6:2];
      rd(s, ix);
      if (ix == 5'h00) chk("r0", gr_rd_data, 32'h0);
      else if (wr_m[s][ix]) chk("reg", gr_rd_data, regs_m[s][ix]);
    end
    t = xs() & 32'hFFFF_FFFC;
    @(posedge clk_sys);
    {instr_valid, branch_taken, link_write} <= 3'h7;
    current_shadow_set <= 2'h0;
    branch_target <= t;
    link_idx <= 5'h1F;
    fin(32'h4);
    x = pc_m + 32'h4;
    chk("br_pc", pc, pc_m);
    chk("slot1", in_delay_slot_flag, 32'h1);
    @(posedge clk_sys);
    instr_valid <= 1'h1;
    fin(32'h0);
    chk("slot_pc", pc, t);
    chk("slot0", in_delay_slot_flag, 32'h0);
    @(posedge clk_sys);
    {instr_valid, jump_assign} <= 2'h3;
    jump_target <= x ^ 32'h40;
    fin(32'h0);
    chk("jump", pc, x ^ 32'h40);
    chk("slot_j", in_delay_slot_flag, 32'h0);
    pc_m = x ^ 32'h40;
    rd(2'h0, 5'h1F);
    chk("link", gr_rd_data, x);
    @(posedge clk_sys);
    {instr_valid, gr_wr_en} <= 2'h3;
    gr_wr_idx <= 5'h03;
    gr_wr_data <= 32'h1234_5678;
    fin(32'h4);
    t = xs();
    @(posedge clk_sys);
    {instr_valid, fault_req, gr_wr_en, load_linked} <= 4'hF;
    gr_wr_data <= 32'hEDCB_A987;
    fault_type <= t[4:0];
    fault_arg <= t;
    fault_vector <= t & 32'hFFFF_FFFC;
    fin(32'h0);
    chk("fault", raise_fault, 32'h1);
    chk("ftype", fault_type_out, t[4:0]);
    chk("farg", fault_arg_out, t);
    chk("restart", restart_addr, {pc_m[31:1], 1'h0});
    chk("rvalid", restart_valid, 32'h1);
    chk("fpc", pc, t & 32'hFFFF_FFFC);
    chk("fll", link_reservation_flag, 32'h0);
    pc_m = t & 32'hFFFF_FFFC;
    rd(2'h0, 5'h03);
    chk("freg", gr_rd_data, 32'h1234_5678);
    go(4'h8);
    chk("ll", link_reservation_flag, 32'h1);
    go(4'h4);
    chk("sc_ok", store_cond_success, 32'h1);
    go(4'h4);
    chk("sc_bad", store_cond_success, 32'h0);
    go(4'h8);
    go(4'h2);
    chk("conflict", link_reservation_flag, 32'h0);
    go(4'h8);
    @(posedge clk_sys);
    {instr_valid, exc_return} <= 2'h3;
    exc_return_pc <= x;
    fin(32'h0);
    chk("eret", link_reservation_flag, 32'h0);
    chk("eret_pc", pc, x);
    pc_m = x;
    @(posedge clk_sys);
    {instr_valid, branch_taken, target_isa} <= 3'h7;
    fin(32'h0);
    @(posedge clk_sys);
    instr_valid <= 1'h1;
    fin(32'h0);
    chk("isa", instruction_set_select, 32'h1);
    pc_m = pc;
    @(posedge clk_sys);
    {instr_valid, instr_short} <= 2'h3;
    fin(32'h2);
    chk("short", pc, pc_m);
    stop_test();
  end
endmodule
bind cas_core_state cas_core_state_asserts chk_i (.*);
